/* File: gps_link_if.sv */
// Link wires between the graphics port device end and the master end
`timescale 1ns/1ps
interface gps_link_if
  import gps_pkg::*;
(
  input wire logic link_clk
);
  gps_bus_t   dev_o;
  gps_bus_t   dev_oe_n;
  gps_bus_t   mst_o;
  gps_bus_t   mst_oe_n;
  gps_bus_t   bus_w;
  logic       bus_grant;
  logic [2:0] grant_status;
  logic       frame_start;
  logic       bus_request;
  logic       read_buffer_full;
  logic       write_buffer_full;
  logic [7:0] mst_sba_o;
  logic       mst_sba_oe_n;
  logic       sba_pullup;
  logic [7:0] sideband_addr_bus;
  logic       sideband_first_strobe;
  logic       sideband_second_strobe;

  // Undriven shared pins settle low; the undriven sideband bus reads all ones while sba_pullup is set
  assign bus_w = gps_bus_t'((~dev_oe_n & dev_o) | (~mst_oe_n & mst_o));
  assign sideband_addr_bus = !mst_sba_oe_n ? mst_sba_o : (sba_pullup ? 8'hff : 8'h00);

  modport dev (
    input  link_clk, bus_w, bus_request, read_buffer_full, write_buffer_full,
    input  sideband_addr_bus, sideband_first_strobe, sideband_second_strobe,
    output dev_o, dev_oe_n, bus_grant, grant_status, frame_start, sba_pullup
  );

  modport mst (
    input  link_clk, bus_w, bus_grant, grant_status, frame_start,
    output mst_o, mst_oe_n, bus_request, read_buffer_full, write_buffer_full,
    output mst_sba_o, mst_sba_oe_n, sideband_first_strobe, sideband_second_strobe
  );
endinterface

/* File: gps_link_props.sv */
// Link wire checks between the device end and the master end
`timescale 1ns/1ps
module gps_link_props
  import gps_pkg::*;
(
  input wire logic       link_clk,
  input wire logic       reset,
  input wire logic       cfg_mode3,
  input wire logic       cfg_rate8x,
  input wire logic       cfg_sband,
  input wire logic       cfg_rbf_impl,
  input wire logic       cfg_wbf_impl,
  input wire gps_bus_t   dev_o,
  input wire gps_bus_t   dev_oe_n,
  input wire gps_bus_t   bus_w,
  input wire logic       bus_grant,
  input wire logic [2:0] grant_status,
  input wire logic       frame_start,
  input wire logic       bus_request,
  input wire logic       read_buffer_full,
  input wire logic       write_buffer_full,
  input wire logic       sba_pullup,
  input wire logic       sideband_first_strobe,
  input wire logic       sideband_second_strobe
);
  default clocking cb @(posedge link_clk);
  endclocking
  default disable iff (reset);

  // ****************
  // Sequences
  // ****************
  sequence s_rd_grant;
    bus_grant && grant_status == GS_RD_LO;
  endsequence
  sequence s_permit;
    bus_grant && grant_status == GS_PERMIT && bus_request;
  endsequence

  // ****************
  // Properties
  // ****************
  a_grant_pulse: assert property (bus_grant |=> !bus_grant)
    else $error("grant longer than one cycle");
  a_status_code: assert property (bus_grant |-> grant_status inside {3'h0, 3'h2, 3'h7} ||
    (!cfg_mode3 && grant_status inside {3'h1, 3'h3})) else $error("reserved grant status");
  a_read_held: assert property (cfg_rbf_impl && bus_grant && grant_status == GS_RD_LO |->
    !($past(read_buffer_full) && $past(read_buffer_full, 2))) else $error("read while full");
  a_read_drive: assert property (s_rd_grant |=> (!dev_oe_n.strobes[0] &&
    dev_o.strobes == STB_FIRST) ##1 dev_oe_n.strobes[0]) else $error("read item timing");
  a_fast_held: assert property (frame_start && cfg_wbf_impl |->
    !($past(write_buffer_full) && $past(write_buffer_full, 2))) else $error("fast while full");
  a_flags_4x: assert property (cfg_mode3 && !cfg_rate8x && !dev_oe_n.lower_flag |->
    !dev_o.lower_flag && !dev_o.pipe_upper) else $error("inversion at 4X");
  a_pipe_mode2: assert property ($rose(bus_request) |-> !cfg_mode3)
    else $error("piped request in 3.0");
  a_permit_queue: assert property (s_permit |=> (bus_w.pipe_upper && !bus_request) ##1
    !bus_w.pipe_upper) else $error("piped request not queued");
  a_pullup_mode: assert property (sba_pullup |-> !cfg_mode3 && cfg_sband)
    else $error("pull-up outside sideband");
  a_sb_strobe: assert property (sideband_first_strobe || sideband_second_strobe |->
    cfg_sband) else $error("sideband strobe unconfigured");
endmodule

/* File: gps_pkg.sv */
// Constants, types and helpers shared by both ends of the graphics port link
//
// Contract
// R01 - Master queues one request per edge while piped
// R02 - Piped queuing only in 2.0; 3.0 pin is flag
// R03 - Upper flag set means bits 31..16 inverted
// R04 - 3.0 at 4X: device never inverts, flags low
// R05 - At 8X device inverts both directions
// R06 - Upper flag timed by strobe pair 1
// R07 - Master sends addresses on 8-bit sideband bus
// R08 - Sideband inputs isolated unless enabled, then pulled up; code pulls up only in 2.0 mode, not in 3.0
// R09 - Master keeps one queuing mechanism until reset
// R10 - Read buffer full holds low-priority read return
// R11 - Write buffer full holds fast-write data
// R12 - Buffer-full inputs sampled at cycle start only
// R13 - Grant status meaningful only while granted
// R14 - Grant status code table; 001/011 reserved in 3.0
// R15 - Code 111 permits master to start transaction
// R16 - Pair 0 times low half in 2.0
// R17 - First strobe marks odd items, second even
// R18 - Pair 1 times upper half, both flags
// R19 - Sideband strobes only once sideband configured
// R20 - Lower flag set means bits 15..0 inverted
// R21 - Unimplemented buffer-full input reads deasserted
package gps_pkg;

  // ****************
  // Encodings
  // ****************
  localparam logic [2:0] GS_RD_LO  = 3'h0;
  localparam logic [2:0] GS_RD_HI  = 3'h1;
  localparam logic [2:0] GS_WR_LO  = 3'h2;
  localparam logic [2:0] GS_WR_HI  = 3'h3;
  localparam logic [2:0] GS_PERMIT = 3'h7;
  localparam logic [2:0] GS_RST    = 3'h0;
  localparam logic [1:0] RX_PIPE   = 2'h0;
  localparam logic [1:0] RX_SBAND  = 2'h1;
  localparam logic [1:0] RX_DATA   = 2'h2;
  localparam logic [1:0] RX_FAST   = 2'h3;
  localparam logic [3:0] STB_FIRST = 4'h5;
  localparam logic [3:0] CBE_ALL   = 4'hf;
  localparam logic [1:0] SB_LAST   = 2'h3;
  localparam int         DBI_LIMIT = 8;
  localparam int         C_M3      = 0;
  localparam int         C_8X      = 1;
  localparam int         C_SB      = 2;
  localparam int         C_RBF     = 3;
  localparam int         C_WBF     = 4;

  typedef enum logic [2:0] {
    DS_IDLE = 3'h0, DS_WAIT = 3'h1, DS_GNT = 3'h2,
    DS_DRIVE = 3'h3, DS_RECV = 3'h4, DS_PERMIT = 3'h5
  } gps_dst_t;

  typedef enum logic [1:0] {
    MS_IDLE = 2'h0, MS_REQ = 2'h1, MS_PIPE = 2'h2, MS_SB = 2'h3
  } gps_mst_t;

  // Shared two-way pins; strobes: [0] pair0 first, [1] pair0 second,
  // [2] pair1 first, [3] pair1 second
  typedef struct packed {
    logic        pipe_upper;
    logic        lower_flag;
    logic [3:0]  strobes;
    logic [3:0]  cmd_be;
    logic [31:0] addr_data;
  } gps_bus_t;

  localparam gps_bus_t BUS_RST = '0;
  localparam gps_bus_t BUS_OFF = '1;

  // ****************
  // Helpers
  // ****************
  function automatic logic [31:0] gps_flip(input logic [31:0] d, input logic [1:0] f);
    return {f[1] ? ~d[31:16] : d[31:16], f[0] ? ~d[15:0] : d[15:0]};
  endfunction

  function automatic logic gps_code_ok(input logic m3, input logic [2:0] c);
    return (c == GS_RD_LO) || (c == GS_WR_LO) || (c == GS_PERMIT) ||
           (!m3 && ((c == GS_RD_HI) || (c == GS_WR_HI)));
  endfunction

  // One data item with its strobe and inversion flags
  function automatic gps_bus_t gps_drive(input logic [31:0] d, input logic [3:0] cbe,
                                         input logic inv_ok, input logic [31:0] prev);
    gps_bus_t   b;
    logic [1:0] f;
    f[1] = inv_ok && ($countones(prev[31:16] ^ d[31:16]) > DBI_LIMIT);
    f[0] = inv_ok && ($countones(prev[15:0] ^ d[15:0]) > DBI_LIMIT);
    b            = BUS_RST;
    b.addr_data  = gps_flip(d, f);
    b.cmd_be     = cbe;
    b.strobes    = STB_FIRST;
    b.pipe_upper = f[1];
    b.lower_flag = f[0];
    return b;
  endfunction

  // Flags are driven only in 3.0 mode, where the pipe pin is the upper flag
  function automatic gps_bus_t gps_drive_en(input logic m3);
    gps_bus_t e;
    e            = BUS_OFF;
    e.addr_data  = '0;
    e.cmd_be     = '0;
    e.strobes    = '0;
    e.pipe_upper = !m3;
    e.lower_flag = !m3;
    return e;
  endfunction

endpackage

/* File: gps_port_dev.sv */
// Device end of the graphics port: arbiter, data mover and request receiver
`timescale 1ns/1ps
module gps_port_dev
  import gps_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset,
  gps_link_if.dev          link,
  input  wire logic        cfg_mode3,
  input  wire logic        cfg_rate8x,
  input  wire logic        cfg_sband,
  input  wire logic        cfg_rbf_impl,
  input  wire logic        cfg_wbf_impl,
  input  wire logic        tx_valid,
  input  wire logic [2:0]  tx_code,
  input  wire logic        tx_fast,
  input  wire logic [31:0] tx_data,
  output logic             tx_ready,
  output logic             rx_valid,
  output logic [1:0]       rx_kind,
  output logic [31:0]      rx_data,
  output logic [3:0]       rx_cbe
);

  // ****************
  // State
  // ****************
  typedef struct packed {
    logic        tx_tog;
    logic [2:0]  code;
    logic        fast;
    logic [31:0] data;
    logic        ack_s1;
    logic        ack_s2;
    logic        ack_seen;
    logic        ready;
    logic        rx_s1;
    logic        rx_s2;
    logic        rx_seen;
    logic        vld;
    logic [1:0]  kind;
    logic [31:0] rdat;
    logic [3:0]  rcbe;
  } gps_dm_t;

  typedef struct packed {
    logic [4:0]  cfg_s1;
    logic [4:0]  cfg_s2;
    logic        tx_s1;
    logic        tx_s2;
    logic        tx_seen;
    logic        ack_tog;
    gps_dst_t    st;
    logic [2:0]  code;
    logic        fast;
    logic [31:0] data;
    logic        rbf;
    logic        wbf;
    logic        gnt;
    logic [2:0]  gs;
    logic        frame;
    logic        pull;
    gps_bus_t    bo;
    gps_bus_t    boe_n;
    logic [31:0] prev;
    logic        rx_tog;
    logic [1:0]  kind;
    logic [31:0] rdat;
    logic [3:0]  rcbe;
  } gps_dl_t;

  gps_dm_t m_q;
  gps_dm_t m_d;
  gps_dl_t l_q;
  gps_dl_t l_d;

  assign tx_ready          = m_q.ready;
  assign rx_valid          = m_q.vld;
  assign rx_kind           = m_q.kind;
  assign rx_data           = m_q.rdat;
  assign rx_cbe            = m_q.rcbe;
  assign link.dev_o        = l_q.bo;
  assign link.dev_oe_n     = l_q.boe_n;
  assign link.bus_grant    = l_q.gnt;
  assign link.grant_status = l_q.gs;
  assign link.frame_start  = l_q.frame;
  assign link.sba_pullup   = l_q.pull;

  // ****************
  // User side
  // ****************
  always_comb begin
    m_d        = m_q;
    m_d.ack_s1 = l_q.ack_tog;
    m_d.ack_s2 = m_q.ack_s1;
    m_d.rx_s1  = l_q.rx_tog;
    m_d.rx_s2  = m_q.rx_s1;
    m_d.vld    = 1'b0;
    if (m_q.ack_s2 != m_q.ack_seen) begin
      m_d.ack_seen = m_q.ack_s2;
      m_d.ready    = 1'b1;
    end
    if (tx_valid && m_q.ready) begin
      m_d.ready  = 1'b0;
      m_d.tx_tog = ~m_q.tx_tog;
      m_d.code   = tx_code;
      m_d.fast   = tx_fast;
      m_d.data   = tx_data;
    end
    // Link words are stable here: the link side changes them only per link cycle
    if (m_q.rx_s2 != m_q.rx_seen) begin
      m_d.rx_seen = m_q.rx_s2;
      m_d.vld     = 1'b1;
      m_d.kind    = l_q.kind;
      m_d.rdat    = l_q.rdat;
      m_d.rcbe    = l_q.rcbe;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      m_q       <= '0;
      m_q.ready <= 1'b1;
    end else begin
      m_q <= m_d;
    end
  end

  // ****************
  // Link side
  // ****************
  always_comb begin
    logic        m3;
    logic        x8;
    logic        p_en;
    logic [1:0]  p_kind;
    logic [31:0] p_dat;
    logic [3:0]  p_cbe;
    gps_bus_t    b;
    m3     = l_q.cfg_s2[C_M3];
    x8     = l_q.cfg_s2[C_8X];
    p_en   = 1'b0;
    p_kind = RX_DATA;
    p_dat  = '0;
    p_cbe  = '0;
    b      = link.bus_w;
    l_d        = l_q;
    l_d.cfg_s1 = {cfg_wbf_impl, cfg_rbf_impl, cfg_sband, cfg_rate8x, cfg_mode3};
    l_d.cfg_s2 = l_q.cfg_s1;
    l_d.tx_s1  = m_q.tx_tog;
    l_d.tx_s2  = l_q.tx_s1;
    l_d.rbf    = link.read_buffer_full & l_q.cfg_s2[C_RBF]; // R12 R21
    l_d.wbf    = link.write_buffer_full & l_q.cfg_s2[C_WBF]; // R12 R21
    l_d.pull   = !m3 && l_q.cfg_s2[C_SB]; // R08
    l_d.gnt    = 1'b0;
    l_d.frame  = 1'b0;
    l_d.boe_n  = BUS_OFF;
    case (l_q.st)
      DS_IDLE: begin
        if (l_q.tx_s2 != l_q.tx_seen) begin
          l_d.tx_seen = l_q.tx_s2;
          l_d.code    = m_q.code;
          l_d.fast    = m_q.fast;
          l_d.data    = m_q.data;
          if (m_q.fast || gps_code_ok(m3, m_q.code)) begin // R14
            l_d.st = DS_WAIT;
          end else begin
            l_d.ack_tog = ~l_q.ack_tog;
          end
        end
      end
      DS_WAIT: begin
        if (l_q.fast) begin
          if (!l_q.wbf) begin // R11
            l_d.frame = 1'b1;
            l_d.bo    = gps_drive(l_q.data, CBE_ALL, m3 && x8, l_q.prev); // R04 R05
            l_d.boe_n = gps_drive_en(m3);
            l_d.prev  = l_d.bo.addr_data;
            l_d.st    = DS_DRIVE;
          end
        end else if (!(l_q.code == GS_RD_LO && l_q.rbf) && // R10
                     (l_q.code != GS_PERMIT || link.bus_request)) begin
          l_d.gnt = 1'b1; // R13
          l_d.gs  = l_q.code;
          l_d.st  = DS_GNT;
        end
      end
      DS_GNT: begin
        if (l_q.code == GS_RD_LO || l_q.code == GS_RD_HI) begin
          l_d.bo    = gps_drive(l_q.data, CBE_ALL, m3 && x8, l_q.prev); // R04 R05 R16 R17
          l_d.boe_n = gps_drive_en(m3); // R06 R18
          l_d.prev  = l_d.bo.addr_data;
          l_d.st    = DS_DRIVE;
        end else if (l_q.code == GS_PERMIT) begin
          l_d.st = DS_PERMIT; // R15
        end else begin
          l_d.st = DS_RECV;
        end
      end
      DS_DRIVE: begin
        l_d.ack_tog = ~l_q.ack_tog;
        l_d.st      = DS_IDLE;
      end
      DS_RECV: begin
        if (|b.strobes) begin // R17
          p_en        = 1'b1;
          p_kind      = RX_DATA;
          p_dat       = gps_flip(b.addr_data,
                                 m3 ? {b.pipe_upper, b.lower_flag} : 2'b00); // R03 R20
          p_cbe       = b.cmd_be;
          l_d.ack_tog = ~l_q.ack_tog;
          l_d.st      = DS_IDLE;
        end
      end
      DS_PERMIT: begin
        if (!m3 && b.pipe_upper) begin // R01 R02
          p_en   = 1'b1;
          p_kind = RX_PIPE;
          p_dat  = b.addr_data;
          p_cbe  = b.cmd_be;
        end else begin
          l_d.ack_tog = ~l_q.ack_tog;
          l_d.st      = DS_IDLE;
        end
      end
      default: begin
        l_d.st = DS_IDLE;
      end
    endcase
    // Sideband bytes, ignored while sideband addressing is off
    if (!p_en && l_q.cfg_s2[C_SB] &&
        (link.sideband_first_strobe || link.sideband_second_strobe)) begin // R07 R08
      p_en   = 1'b1;
      p_kind = RX_SBAND;
      p_dat  = {24'h000000, link.sideband_addr_bus};
      p_cbe  = '0;
    end
    if (p_en) begin
      l_d.rx_tog = ~l_q.rx_tog;
      l_d.kind   = p_kind;
      l_d.rdat   = p_dat;
      l_d.rcbe   = p_cbe;
    end
  end

  always_ff @(posedge link.link_clk or posedge reset) begin
    if (reset) begin
      l_q       <= '0;
      l_q.st    <= DS_IDLE;
      l_q.gs    <= GS_RST;
      l_q.boe_n <= BUS_OFF;
    end else begin
      l_q <= l_d;
    end
  end

endmodule

/* File: gps_port_mst.sv */
// Master end of the graphics port: request queuing and data exchange
`timescale 1ns/1ps
module gps_port_mst
  import gps_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset,
  gps_link_if.mst          link,
  input  wire logic        cfg_mode3,
  input  wire logic        cfg_rate8x,
  input  wire logic        cfg_sband,
  input  wire logic        buf_rd_full,
  input  wire logic        buf_wr_full,
  input  wire logic        req_valid,
  input  wire logic [31:0] req_addr,
  input  wire logic [3:0]  req_cmd,
  input  wire logic [31:0] req_wdata,
  output logic             req_ready,
  output logic             rx_valid,
  output logic             rx_fast,
  output logic [31:0]      rx_data
);

  // ****************
  // State
  // ****************
  typedef struct packed {
    logic        tx_tog;
    logic [31:0] addr;
    logic [3:0]  cmd;
    logic [31:0] wdat;
    logic        ack_s1;
    logic        ack_s2;
    logic        ack_seen;
    logic        ready;
    logic        rx_s1;
    logic        rx_s2;
    logic        rx_seen;
    logic        vld;
    logic        fast;
    logic [31:0] rdat;
  } gps_mm_t;

  typedef struct packed {
    logic [2:0]  cfg_s1;
    logic [2:0]  cfg_s2;
    logic [1:0]  fl_s1;
    logic [1:0]  fl_s2;
    logic        tx_s1;
    logic        tx_s2;
    logic        tx_seen;
    logic        ack_tog;
    logic        mech_set;
    logic        mech_sb;
    gps_mst_t    st;
    logic [1:0]  sbn;
    logic        req;
    gps_bus_t    bo;
    gps_bus_t    boe_n;
    logic [7:0]  sba;
    logic        sba_oe_n;
    logic [1:0]  sbstb;
    logic [31:0] prev;
    logic        rx_tog;
    logic        fast;
    logic [31:0] rdat;
  } gps_ml_t;

  gps_mm_t m_q;
  gps_mm_t m_d;
  gps_ml_t l_q;
  gps_ml_t l_d;

  assign req_ready                   = m_q.ready;
  assign rx_valid                    = m_q.vld;
  assign rx_fast                     = m_q.fast;
  assign rx_data                     = m_q.rdat;
  assign link.mst_o                  = l_q.bo;
  assign link.mst_oe_n               = l_q.boe_n;
  assign link.bus_request            = l_q.req;
  assign link.read_buffer_full       = l_q.fl_s2[0];
  assign link.write_buffer_full      = l_q.fl_s2[1];
  assign link.mst_sba_o              = l_q.sba;
  assign link.mst_sba_oe_n           = l_q.sba_oe_n;
  assign link.sideband_first_strobe  = l_q.sbstb[0];
  assign link.sideband_second_strobe = l_q.sbstb[1];

  // ****************
  // User side
  // ****************
  always_comb begin
    m_d        = m_q;
    m_d.ack_s1 = l_q.ack_tog;
    m_d.ack_s2 = m_q.ack_s1;
    m_d.rx_s1  = l_q.rx_tog;
    m_d.rx_s2  = m_q.rx_s1;
    m_d.vld    = 1'b0;
    if (m_q.ack_s2 != m_q.ack_seen) begin
      m_d.ack_seen = m_q.ack_s2;
      m_d.ready    = 1'b1;
    end
    if (req_valid && m_q.ready) begin
      m_d.ready  = 1'b0;
      m_d.tx_tog = ~m_q.tx_tog;
      m_d.addr   = req_addr;
      m_d.cmd    = req_cmd;
      m_d.wdat   = req_wdata;
    end
    if (m_q.rx_s2 != m_q.rx_seen) begin
      m_d.rx_seen = m_q.rx_s2;
      m_d.vld     = 1'b1;
      m_d.fast    = l_q.fast;
      m_d.rdat    = l_q.rdat;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      m_q       <= '0;
      m_q.ready <= 1'b1;
    end else begin
      m_q <= m_d;
    end
  end

  // ****************
  // Link side
  // ****************
  always_comb begin
    logic     m3;
    logic     sb;
    gps_bus_t b;
    m3 = l_q.cfg_s2[C_M3];
    sb = l_q.mech_set ? l_q.mech_sb : l_q.cfg_s2[C_SB];
    b  = link.bus_w;
    l_d          = l_q;
    l_d.cfg_s1   = {cfg_sband, cfg_rate8x, cfg_mode3};
    l_d.cfg_s2   = l_q.cfg_s1;
    l_d.fl_s1    = {buf_wr_full, buf_rd_full};
    l_d.fl_s2    = l_q.fl_s1;
    l_d.boe_n    = BUS_OFF;
    l_d.sba_oe_n = 1'b1;
    l_d.sbstb    = 2'b00;
    // Data phases asked for by the grant, in any state
    if (link.bus_grant && gps_code_ok(m3, link.grant_status) && // R13 R14
        (link.grant_status == GS_WR_LO || link.grant_status == GS_WR_HI)) begin
      l_d.bo    = gps_drive(m_q.wdat, CBE_ALL, m3 && l_q.cfg_s2[C_8X], l_q.prev);
      l_d.boe_n = gps_drive_en(m3);
      l_d.prev  = l_d.bo.addr_data;
    end
    if (&l_q.boe_n.strobes && |b.strobes) begin
      l_d.rx_tog = ~l_q.rx_tog;
      l_d.fast   = link.frame_start;
      l_d.rdat   = gps_flip(b.addr_data, m3 ? {b.pipe_upper, b.lower_flag} : 2'b00); // R03 R20
    end
    case (l_q.st)
      MS_IDLE: begin
        if (l_q.tx_s2 != l_q.tx_seen) begin
          l_d.tx_seen  = l_q.tx_s2;
          l_d.mech_set = 1'b1; // R09
          l_d.mech_sb  = sb;
          if (sb && l_q.cfg_s2[C_SB]) begin
            l_d.st  = MS_SB;
            l_d.sbn = 2'h0;
          end else if (!sb && !m3) begin // R02
            l_d.req = 1'b1;
            l_d.st  = MS_REQ;
          end else begin
            l_d.ack_tog = ~l_q.ack_tog;
          end
        end
      end
      MS_REQ: begin
        if (link.bus_grant && link.grant_status == GS_PERMIT) begin // R13 R15
          l_d.bo            = BUS_RST;
          l_d.bo.addr_data  = m_q.addr;
          l_d.bo.cmd_be     = m_q.cmd;
          l_d.bo.pipe_upper = 1'b1; // R01
          l_d.boe_n         = BUS_OFF;
          l_d.boe_n.addr_data  = '0;
          l_d.boe_n.cmd_be     = '0;
          l_d.boe_n.pipe_upper = 1'b0;
          l_d.req = 1'b0;
          l_d.st  = MS_PIPE;
        end
      end
      MS_PIPE: begin
        l_d.ack_tog = ~l_q.ack_tog;
        l_d.st      = MS_IDLE;
      end
      MS_SB: begin
        l_d.sba      = m_q.addr[8 * (3 - l_q.sbn) +: 8]; // R07
        l_d.sba_oe_n = 1'b0;
        l_d.sbstb    = l_q.sbn[0] ? 2'b10 : 2'b01; // R17 R19
        l_d.sbn      = l_q.sbn + 2'h1;
        if (l_q.sbn == SB_LAST) begin
          l_d.ack_tog = ~l_q.ack_tog;
          l_d.st      = MS_IDLE;
        end
      end
      default: begin
        l_d.st = MS_IDLE;
      end
    endcase
    l_d.tx_s1 = m_q.tx_tog;
    l_d.tx_s2 = l_q.tx_s1;
  end

  always_ff @(posedge link.link_clk or posedge reset) begin
    if (reset) begin
      l_q          <= '0;
      l_q.st       <= MS_IDLE;
      l_q.boe_n    <= BUS_OFF;
      l_q.sba_oe_n <= 1'b1;
    end else begin
      l_q <= l_d;
    end
  end

endmodule

/* File: graphics_port_signaling_tb.sv */
// Self-checking bench joining the device end and the master end over the link
`timescale 1ns/1ps
module graphics_port_signaling_tb;
  import gps_pkg::*;

  // ****************
  // Signals
  // ****************
  logic        mclk, link_clk, reset;
  logic        m3, x8, sb, rbi, wbi;
  logic        tx_valid, tx_fast, tx_ready, d_rx_valid;
  logic [2:0]  tx_code;
  logic [31:0] tx_data, d_rx_data;
  logic [1:0]  d_rx_kind;
  logic [3:0]  d_rx_cbe, req_cmd, c;
  logic        buf_rd_full, buf_wr_full, req_valid, req_ready, m_rx_valid, m_rx_fast;
  logic [31:0] req_addr, req_wdata, m_rx_data, a, w, d;
  logic [37:0] dq[$];
  logic [32:0] mq[$];
  logic [37:0] de;
  logic        inv_seen;
  int          errors, check_count, cycles, seed, i;

  gps_link_if u_gps_link_if (.link_clk(link_clk));

  gps_port_dev u_gps_port_dev (.mclk(mclk), .reset(reset), .link(u_gps_link_if),
    .cfg_mode3(m3), .cfg_rate8x(x8), .cfg_sband(sb), .cfg_rbf_impl(rbi), .cfg_wbf_impl(wbi),
    .tx_valid(tx_valid), .tx_code(tx_code), .tx_fast(tx_fast), .tx_data(tx_data),
    .tx_ready(tx_ready), .rx_valid(d_rx_valid), .rx_kind(d_rx_kind), .rx_data(d_rx_data),
    .rx_cbe(d_rx_cbe));

  gps_port_mst u_gps_port_mst (.mclk(mclk), .reset(reset), .link(u_gps_link_if),
    .cfg_mode3(m3), .cfg_rate8x(x8), .cfg_sband(sb), .buf_rd_full(buf_rd_full),
    .buf_wr_full(buf_wr_full), .req_valid(req_valid), .req_addr(req_addr),
    .req_cmd(req_cmd), .req_wdata(req_wdata), .req_ready(req_ready),
    .rx_valid(m_rx_valid), .rx_fast(m_rx_fast), .rx_data(m_rx_data));

  gps_link_props u_gps_link_props (.link_clk(link_clk), .reset(reset), .cfg_mode3(m3),
    .cfg_rate8x(x8), .cfg_sband(sb), .cfg_rbf_impl(rbi), .cfg_wbf_impl(wbi),
    .dev_o(u_gps_link_if.dev_o), .dev_oe_n(u_gps_link_if.dev_oe_n),
    .bus_w(u_gps_link_if.bus_w), .bus_grant(u_gps_link_if.bus_grant),
    .grant_status(u_gps_link_if.grant_status), .frame_start(u_gps_link_if.frame_start),
    .bus_request(u_gps_link_if.bus_request),
    .read_buffer_full(u_gps_link_if.read_buffer_full),
    .write_buffer_full(u_gps_link_if.write_buffer_full),
    .sba_pullup(u_gps_link_if.sba_pullup),
    .sideband_first_strobe(u_gps_link_if.sideband_first_strobe),
    .sideband_second_strobe(u_gps_link_if.sideband_second_strobe));

  // ****************
  // Clocks and monitors
  // ****************
  always #4 mclk = ~mclk;

  initial begin
    link_clk = 1'b0;
    #13.7;
    forever #40 link_clk = ~link_clk;
  end

  always @(posedge link_clk) begin
    if (u_gps_link_if.dev_oe_n.lower_flag === 1'b0 &&
        u_gps_link_if.dev_o.lower_flag === 1'b1) begin
      inv_seen = 1'b1;
    end
  end

  always @(posedge mclk) begin
    cycles++;
    if (d_rx_valid === 1'b1) begin
      de = dq.size() ? dq.pop_front() : '1;
      chk({d_rx_kind, d_rx_kind == 2'h0 ? d_rx_cbe : 4'h0, d_rx_kind == 2'h1 ?
        {24'h0, d_rx_data[7:0]} : d_rx_data} === de, "device item");
    end
    if (m_rx_valid === 1'b1) begin
      chk({m_rx_fast, m_rx_data} === (mq.size() ? mq.pop_front() : '1), "master item");
    end
    if (cycles == 30000) begin
      chk(1'b0, "timeout");
      end_of_test;
    end
  end

  // ****************
  // Tasks
  // ****************
  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      errors++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  task automatic tick;
    @(posedge mclk);
    #1;
  endtask

  task automatic wait_hi(input bit sel);
    int n;
    n = 0;
    while ((sel ? req_ready : tx_ready) !== 1'b1 && n < 600) begin
      tick;
      n++;
    end
    chk(n < 600, "handshake stuck");
  endtask

  task automatic dev_tx(input logic [2:0] code, input logic f, input logic [31:0] v);
    wait_hi(1'b0);
    {tx_valid, tx_code, tx_fast, tx_data} = {1'b1, code, f, v};
    tick;
    tx_valid = 1'b0;
  endtask

  task automatic mst_req(input logic [31:0] ad, input logic [3:0] cm, input logic [31:0] wd);
    wait_hi(1'b1);
    {req_valid, req_addr, req_cmd, req_wdata} = {1'b1, ad, cm, wd};
    tick;
    req_valid = 1'b0;
  endtask

  task automatic settle;
    repeat (200) tick;
    chk(dq.size() == 0 && mq.size() == 0, "result missing");
  endtask

  task automatic restart(input logic [4:0] cf, input logic rf, input logic wf);
    reset = 1'b1;
    {m3, x8, sb, rbi, wbi} = cf;
    {buf_rd_full, buf_wr_full} = {rf, wf};
    repeat (6) @(posedge link_clk);
    tick;
    reset = 1'b0;
    inv_seen = 1'b0;
    repeat (40) tick;
  endtask

  task automatic end_of_test;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ****************
  // Scenarios
  // ****************
  initial begin
    seed = 32'hb9a3;
    mclk = 1'b0;
    {tx_valid, tx_fast, req_valid, tx_code, tx_data} = '0;
    {req_addr, req_wdata, req_cmd} = '0;
    restart(5'h03, 1'b0, 1'b0);
    for (i = 0; i < 3; i++) begin
      a = $random(seed);
      w = $random(seed);
      c = 4'($random(seed));
      d = $random(seed);
      dq.push_back({2'h0, c, a});
      mst_req(a, c, w);
      dev_tx(GS_PERMIT, 1'b0, 32'h0);
      dq.push_back({2'h2, 4'h0, w});
      dev_tx(GS_WR_LO, 1'b0, 32'h0);
      dq.push_back({2'h2, 4'h0, w});
      dev_tx(GS_WR_HI, 1'b0, 32'h0);
      mq.push_back({1'b0, d});
      dev_tx(GS_RD_HI, 1'b0, d);
      settle;
    end
    for (i = 0; i < 2; i++) begin
      {buf_wr_full, buf_rd_full} = 2'h3;
      repeat (40) tick;
      dev_tx(GS_RD_LO, i[0], d);
      repeat (200) tick;
      mq.push_back({i[0], d});
      {buf_wr_full, buf_rd_full} = 2'h0;
      settle;
    end
    restart(5'h1b, 1'b0, 1'b0);
    for (i = 0; i < 6; i++) begin
      d = (i < 2) ? {32{i[0]}} : $random(seed);
      mq.push_back({1'b0, d});
      dev_tx(GS_RD_LO, 1'b0, d);
    end
    for (i = 1; i < 7; i++) begin
      if (i != 2) dev_tx(3'(i), 1'b0, d);
    end
    w = $random(seed);
    mst_req(32'h0, 4'h0, w);
    dq.push_back({2'h2, 4'h0, w});
    dev_tx(GS_WR_LO, 1'b0, 32'h0);
    settle;
    chk(inv_seen, "no inversion at 8X");
    restart(5'h07, 1'b0, 1'b0);
    a = $random(seed);
    for (i = 3; i >= 0; i--) dq.push_back({2'h1, 28'h0, a[8*i +: 8]});
    mst_req(a, 4'h0, 32'h0);
    settle;
    restart(5'h10, 1'b1, 1'b1);
    for (i = 0; i < 4; i++) begin
      mq.push_back({i[1], {32{i[0]}}});
      dev_tx(GS_RD_LO, i[1], {32{i[0]}});
    end
    settle;
    chk(!inv_seen, "inversion at 4X");
    end_of_test;
  end
endmodule
